// ==== hw/pec_pkg.sv ====
// shared constants for the two-counter performance monitor
// assumes a single system clock domain and a synchronous active-high reset
package pec_pkg;

	// counter width and pin lag in clocks
	localparam int CNT_W   = 40;
	localparam int PIN_LAG = 5;

	// register selects on the model-specific register port
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_CNT0 = 2'h1;
	localparam logic [1:0] SEL_CNT1 = 2'h2;

	// control register field positions and widths
	localparam int ES_W     = 6;
	localparam int CC_W     = 3;
	localparam int CODE0_LSB = 0;
	localparam int MODE0_LSB = 6;
	localparam int PF0_LSB   = 9;
	localparam int CODE1_LSB = 16;
	localparam int MODE1_LSB = 22;
	localparam int PF1_LSB   = 25;

	// count mode bits: low privilege, user level, clock counting
	localparam int CC_LOW = 0;
	localparam int CC_USR = 1;
	localparam int CC_CLK = 2;

	// reset value and the writable bits of the control register
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h03ff_03ff;

	// field extraction, used once per counter
	function automatic logic [ES_W-1:0] ctl_code(input logic [31:0] c, input logic idx);
		ctl_code = idx ? c[CODE1_LSB +: ES_W] : c[CODE0_LSB +: ES_W];
	endfunction

	function automatic logic [CC_W-1:0] ctl_mode(input logic [31:0] c, input logic idx);
		ctl_mode = idx ? c[MODE1_LSB +: CC_W] : c[MODE0_LSB +: CC_W];
	endfunction

	function automatic logic ctl_pinf(input logic [31:0] c, input logic idx);
		ctl_pinf = idx ? c[PF1_LSB] : c[PF0_LSB];
	endfunction

endpackage

// ==== hw/pec_counter.sv ====
// one performance counter with its pin indication delay line
// assumes event inputs are synchronous and one bit per event code
`timescale 1ns/1ps
module pec_counter
	import pec_pkg::*;
#(
	parameter int W   = CNT_W,
	parameter int LAG = PIN_LAG
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [CC_W-1:0]  mode,
	input  wire logic             pin_fn,
	input  wire logic [ES_W-1:0]  code,
	input  wire logic [63:0]      evt_lvl,
	input  wire logic [63:0]      evt_two,
	input  wire logic [1:0]       priv_lvl,
	input  wire logic             wr_en,
	input  wire logic [W-1:0]     wr_val,
	output logic      [W-1:0]     count,
	output logic                  pin_dly
);

	generate
		if (W < 2 || W > 63) begin : g_bad_w
			$error("pec_counter: width out of range");
		end
		if (LAG < 3) begin : g_bad_lag
			$error("pec_counter: pin lag too short");
		end
	endgenerate

	typedef struct packed {
		logic [W-1:0]   cnt;
		logic [LAG-2:0] chain;
	} pec_cnt_t;

	pec_cnt_t st_r;
	pec_cnt_t st_nxt;
	logic     priv_ok;
	logic     run;
	logic     two;
	logic     ovf;
	logic     raw;
	logic [W:0] sum;

	// advance, wrap and pin source; a write beats counting in the same clock
	always_comb begin
		priv_ok = (priv_lvl == 2'h3) ? mode[CC_USR] : mode[CC_LOW];
		run     = priv_ok & evt_lvl[code];
		two     = run & ~mode[CC_CLK] & evt_two[code];
		sum     = {1'b0, st_r.cnt} + {{(W-1){1'b0}}, two, run & ~two};
		ovf     = run & ~wr_en & sum[W];
		raw     = pin_fn ? ovf : run;
		st_nxt       = st_r;
		st_nxt.cnt   = wr_en ? wr_val : sum[W-1:0];
		st_nxt.chain = {st_r.chain[LAG-3:0], raw};
	end

	// reset clears the count and the pin delay line so no stale pulse escapes
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.chain <= '0;
			st_r.cnt   <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count   = st_r.cnt;
	assign pin_dly = st_r.chain[LAG-2];

	AST_WRITE_LOAD: assert property (@(posedge clk) disable iff (rst)
		wr_en |=> count == $past(wr_val))
		else $error("counter write not loaded");

	AST_DUR_STEP: assert property (@(posedge clk) disable iff (rst)
		(run && mode[CC_CLK] && !wr_en) |=> count == W'($past(count) + 1))
		else $error("duration count did not add one");

	AST_DOUBLE: assert property (@(posedge clk) disable iff (rst)
		(two && !wr_en) |=> count == W'($past(count) + 2))
		else $error("double event did not add two");

	AST_IDLE: assert property (@(posedge clk) disable iff (rst)
		(mode[CC_USR:CC_LOW] == 2'h0 && !wr_en) |=> $stable(count))
		else $error("disabled counter moved");

	AST_WRAP: assert property (@(posedge clk) disable iff (rst)
		(run && !two && !wr_en && &count) |=> count == '0)
		else $error("counter did not wrap to zero");

	AST_LAG: assert property (@(posedge clk) disable iff (rst)
		raw |-> ##4 pin_dly)
		else $error("pin indication not delayed as expected");

endmodule

// ==== hw/pec_top.sv ====
// two-counter performance monitor with control register and monitor pins
// assumes the processor presents one register access per cycle on the msr port
// and that event lines are synchronous to CLK
//
// Summary of operation
// - two independent 40-bit counters count events or clocks of a condition
// - register reads and writes only succeed at privilege level zero
// - control holds 6-bit event codes at bits 0-5 and 16-21
// - each counter has a 3-bit mode field at bits 6-8 and 22-24
// - mode low bit levels 0-2, middle level 3, high selects clocks
// - pin indications lag the internal event by a few clocks
// - overflow appears on its pin about five clocks after the wrap
// - reset clears the whole control register, disabling both counters
// - pin asserts once per advancing clock even when count adds two
// - duration counts add one per clock; pin holds throughout
// - overflow is the carry out of bit 39
// - pins follow BP_MODE, which reset does not touch; breakpoint mode removes counter indication
`timescale 1ns/1ps
module pec_top
	import pec_pkg::*;
#(
	parameter int CW = CNT_W
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [1:0]  MSR_SEL,
	input  wire logic        MSR_WR,
	input  wire logic        MSR_RD,
	input  wire logic [63:0] MSR_WDATA,
	input  wire logic [1:0]  CURRENT_PRIVILEGE_LEVEL,
	input  wire logic [63:0] EVT_LVL,
	input  wire logic [63:0] EVT_TWO,
	input  wire logic        BP_MODE,
	input  wire logic [1:0]  BP_MATCH,
	output logic      [63:0] MSR_RDATA,
	output logic             MSR_ACK,
	output logic             MSR_FAULT,
	output logic             MONITOR_PIN_ZERO,
	output logic             MONITOR_PIN_ONE
);

	generate
		if (CW < 2 || CW > 63) begin : g_bad_cw
			$error("pec_top: counter width out of range");
		end
	endgenerate

	typedef struct packed {
		logic [31:0] ctrl;
		logic [63:0] rdata;
		logic        ack;
		logic        fault;
		logic [1:0]  pins;
	} pec_top_t;

	pec_top_t       st_r;
	pec_top_t       st_nxt;
	logic           req;
	logic           priv_ok;
	logic           mapped;
	logic [1:0]     cnt_wr;
	logic [CW-1:0]  cnt_val [2];
	logic [1:0]     pin_cnt;

	// decode of the access; privilege and address checked together
	always_comb begin
		req     = MSR_WR | MSR_RD;
		priv_ok = CURRENT_PRIVILEGE_LEVEL == 2'h0;
		mapped  = MSR_SEL == SEL_CTRL || MSR_SEL == SEL_CNT0 || MSR_SEL == SEL_CNT1;
		cnt_wr[0] = MSR_WR & priv_ok & (MSR_SEL == SEL_CNT0);
		cnt_wr[1] = MSR_WR & priv_ok & (MSR_SEL == SEL_CNT1);
	end

	// the two counters share the event lines; each picks its own code
	for (genvar i = 0; i < 2; i++) begin : g_cnt
		pec_counter #(
			.W   (CW),
			.LAG (PIN_LAG)
		) u_cnt (
			.clk     (CLK),
			.rst     (RST),
			.mode    (ctl_mode(st_r.ctrl, 1'(i))),
			.pin_fn  (ctl_pinf(st_r.ctrl, 1'(i))),
			.code    (ctl_code(st_r.ctrl, 1'(i))),
			.evt_lvl (EVT_LVL),
			.evt_two (EVT_TWO),
			.priv_lvl(CURRENT_PRIVILEGE_LEVEL),
			.wr_en   (cnt_wr[i]),
			.wr_val  (MSR_WDATA[CW-1:0]),
			.count   (cnt_val[i]),
			.pin_dly (pin_cnt[i])
		);
	end

	// register file, answer and pin mux
	// the whole control word is written at once; there is no per-field write
	always_comb begin
		st_nxt       = st_r;
		st_nxt.ack   = req & priv_ok & mapped;
		st_nxt.fault = req & ~(priv_ok & mapped);
		if (MSR_WR && priv_ok && MSR_SEL == SEL_CTRL) begin
			st_nxt.ctrl = MSR_WDATA[31:0] & CTRL_MASK;
		end
		// reads sample the counters live; no need to stop them first
		st_nxt.rdata = 64'h0;
		if (MSR_RD && !MSR_WR && priv_ok) begin
			case (MSR_SEL)
				SEL_CTRL: st_nxt.rdata = {32'h0, st_r.ctrl};
				SEL_CNT0: st_nxt.rdata = {{(64-CW){1'b0}}, cnt_val[0]};
				SEL_CNT1: st_nxt.rdata = {{(64-CW){1'b0}}, cnt_val[1]};
				default:  st_nxt.rdata = 64'h0;
			endcase
		end
		// breakpoint mode takes the pins; counter indication is simply lost
		st_nxt.pins = BP_MODE ? BP_MATCH : pin_cnt;
	end

	// reset leaves both counters disabled and both pin registers low; pin use follows BP_MODE
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r.ctrl  <= CTRL_RST;
			st_r.rdata <= 64'h0;
			st_r.ack   <= 1'b0;
			st_r.fault <= 1'b0;
			st_r.pins  <= 2'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign MSR_RDATA        = st_r.rdata;
	assign MSR_ACK          = st_r.ack;
	assign MSR_FAULT        = st_r.fault;
	assign MONITOR_PIN_ZERO = st_r.pins[0];
	assign MONITOR_PIN_ONE  = st_r.pins[1];

	AST_RESET_CTRL: assert property (@(posedge CLK)
		RST |=> st_r.ctrl == 32'h0 && !MONITOR_PIN_ZERO && !MONITOR_PIN_ONE)
		else $error("control not cleared by reset");

	AST_PRIV_FAULT: assert property (@(posedge CLK) disable iff (RST)
		(MSR_WR && CURRENT_PRIVILEGE_LEVEL != 2'h0) |=> MSR_FAULT && !MSR_ACK && $stable(st_r.ctrl))
		else $error("unprivileged write not refused");

	AST_CTRL_WRITE: assert property (@(posedge CLK) disable iff (RST)
		(MSR_WR && priv_ok && MSR_SEL == SEL_CTRL)
		|=> st_r.ctrl == ($past(MSR_WDATA[31:0]) & CTRL_MASK) && MSR_ACK)
		else $error("control write not taken");

	AST_CTRL_READ: assert property (@(posedge CLK) disable iff (RST)
		(MSR_RD && !MSR_WR && priv_ok && MSR_SEL == SEL_CTRL)
		|=> MSR_RDATA == {32'h0, $past(st_r.ctrl)})
		else $error("control read returned wrong value");

	AST_BP_OVERRIDE: assert property (@(posedge CLK) disable iff (RST)
		BP_MODE |=> {MONITOR_PIN_ONE, MONITOR_PIN_ZERO} == $past(BP_MATCH))
		else $error("breakpoint mode did not own the pins");

	AST_PIN_FROM_CNT: assert property (@(posedge CLK) disable iff (RST)
		!BP_MODE |=> MONITOR_PIN_ZERO == $past(pin_cnt[0]))
		else $error("monitor pin not driven by counter");

	// answers on the register port: one cycle, one kind, data only on reads
	// a refused access must leave every register as it was, so the fault
	// checks below also watch the counter load strobes

	AST_QUIET_PORT: assert property (@(posedge CLK) disable iff (RST)
		!req |=> !MSR_ACK && !MSR_FAULT && MSR_RDATA == 64'h0)
		else $error("answer without a request");

	AST_UNMAPPED: assert property (@(posedge CLK) disable iff (RST)
		(req && MSR_SEL != SEL_CTRL && MSR_SEL != SEL_CNT0 && MSR_SEL != SEL_CNT1)
		|=> MSR_FAULT && !MSR_ACK && MSR_RDATA == 64'h0)
		else $error("unmapped select not refused");

	AST_GOOD_ACK: assert property (@(posedge CLK) disable iff (RST)
		(req && CURRENT_PRIVILEGE_LEVEL == 2'h0 && mapped) |=> MSR_ACK && !MSR_FAULT)
		else $error("privileged access not acknowledged");

	AST_USER_READ: assert property (@(posedge CLK) disable iff (RST)
		(MSR_RD && CURRENT_PRIVILEGE_LEVEL != 2'h0) |=> MSR_FAULT && MSR_RDATA == 64'h0)
		else $error("unprivileged read returned data");

	AST_WRITE_NO_DATA: assert property (@(posedge CLK) disable iff (RST)
		MSR_WR |=> MSR_RDATA == 64'h0)
		else $error("read data shown on a write cycle");

	AST_CNT0_READ: assert property (@(posedge CLK) disable iff (RST)
		(MSR_RD && !MSR_WR && priv_ok && MSR_SEL == SEL_CNT0)
		|=> MSR_RDATA == 64'($past(cnt_val[0])))
		else $error("counter zero read returned wrong value");

	AST_CNT1_READ: assert property (@(posedge CLK) disable iff (RST)
		(MSR_RD && !MSR_WR && priv_ok && MSR_SEL == SEL_CNT1)
		|=> MSR_RDATA == 64'($past(cnt_val[1])))
		else $error("counter one read returned wrong value");

	AST_CNT0_LOAD: assert property (@(posedge CLK) disable iff (RST)
		(MSR_WR && priv_ok && MSR_SEL == SEL_CNT0) |-> cnt_wr == 2'h1)
		else $error("counter zero load strobe missing");

	AST_NO_USER_LOAD: assert property (@(posedge CLK) disable iff (RST)
		CURRENT_PRIVILEGE_LEVEL != 2'h0 |-> cnt_wr == 2'h0)
		else $error("counter load at nonzero privilege");

	AST_CTRL_HOLD: assert property (@(posedge CLK) disable iff (RST)
		!(MSR_WR && priv_ok && MSR_SEL == SEL_CTRL) |=> $stable(st_r.ctrl))
		else $error("control changed without a write");

	AST_RESERVED: assert property (@(posedge CLK) disable iff (RST)
		(st_r.ctrl & ~CTRL_MASK) == 32'h0)
		else $error("reserved control bit set");

	AST_PIN_ONE_FROM_CNT: assert property (@(posedge CLK) disable iff (RST)
		!BP_MODE |=> MONITOR_PIN_ONE == $past(pin_cnt[1]))
		else $error("monitor pin one not driven by counter");

	AST_RESET_PORT: assert property (@(posedge CLK)
		RST |=> !MSR_ACK && !MSR_FAULT && MSR_RDATA == 64'h0)
		else $error("register port not quiet after reset");

endmodule

// ==== dv/pec_pin_watch.sv ====
// external observer of the two monitor pins
// assumes the pins are synchronous to the system clock and read mid-cycle
`timescale 1ns/1ps
module pec_pin_watch (
	input  wire logic clk,
	input  wire logic clr,
	input  wire logic pin0,
	input  wire logic pin1,
	output int        n0,
	output int        n1
);
	// tally of clocks with each pin high; one tally per clock, not per count
	always @(negedge clk) begin
		if (clr) begin
			n0 <= 0;
			n1 <= 0;
		end else begin
			n0 <= n0 + int'(pin0);
			n1 <= n1 + int'(pin1);
		end
	end
endmodule

// ==== dv/perf_event_counter_pair_tb.sv ====
// self-checking bench for the two-counter performance monitor
// assumes pec_top and the pin observer; answers are matched in order
`timescale 1ns/1ps
module perf_event_counter_pair_tb;
	import pec_pkg::*;
	localparam logic [64:0] OK_W = 65'h0;
	localparam logic [64:0] FLT  = {1'b1, 64'h0};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        clr = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        bpm = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [1:0]  plvl = 2'h0;
	logic [1:0]  bpx = 2'h0;
	logic [63:0] wdata = 64'h0;
	logic [63:0] evt = 64'h0;
	logic [63:0] two = 64'h0;
	logic [63:0] rdata;
	logic [63:0] d;
	logic        ack;
	logic        fault;
	logic        pin0;
	logic        pin1;
	logic [64:0] expq[$];
	logic [39:0] e0 = 40'h0;
	logic [39:0] e1 = 40'h0;
	logic [5:0]  b;
	int          p0 = 0;
	int          p1 = 0;
	int          n0;
	int          n1;
	int          cyc = 0;
	int          miscompares = 0;
	int          checks_done = 0;

	// 25 MHz system clock
	always #20 clk = ~clk;

	pec_top i_dut (.CLK(clk), .RST(rst), .MSR_SEL(sel), .MSR_WR(wr), .MSR_RD(rd),
		.MSR_WDATA(wdata), .CURRENT_PRIVILEGE_LEVEL(plvl), .EVT_LVL(evt), .EVT_TWO(two),
		.BP_MODE(bpm), .BP_MATCH(bpx), .MSR_RDATA(rdata), .MSR_ACK(ack),
		.MSR_FAULT(fault), .MONITOR_PIN_ZERO(pin0), .MONITOR_PIN_ONE(pin1));
	pec_pin_watch i_watch (.clk(clk), .clr(clr), .pin0(pin0), .pin1(pin1), .n0(n0),
		.n1(n1));

	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one register access; the expected answer is queued for the watcher
	task automatic acc(input logic [1:0] s, input logic w, input logic [63:0] v,
		input logic [1:0] c, input logic [64:0] e);
		@(posedge clk);
		sel <= s;
		wr <= w;
		rd <= !w;
		wdata <= v;
		plvl <= c;
		expq.push_back(e);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		plvl <= 2'h0;
	endtask

	function automatic logic [63:0] ctl(input logic [2:0] m0, input logic p0,
		input logic [2:0] m1, input logic p1);
		return 64'({p1, m1, b, 6'h0, p0, m0, b});
	endfunction

	// random hits on event line b; double hits add two only when counting events
	// en[0] expects counter zero to count events, en[1] counter one to count clocks
	task automatic burst(input int n, input logic [1:0] en);
		logic hit;
		logic dbl;
		repeat (n) begin
			@(posedge clk);
			hit = 1'($urandom);
			dbl = 1'($urandom);
			evt <= 64'(hit) << b;
			two <= 64'(hit & dbl) << b;
			if (en[0] && hit) begin
				e0 += dbl ? 40'h2 : 40'h1;
				p0++;
			end
			if (en[1] && hit) begin
				e1 += 40'h1;
				p1++;
			end
		end
		@(posedge clk);
		evt <= 64'h0;
		two <= 64'h0;
	endtask

	// every ack or fault consumes the oldest note
	always @(negedge clk) begin
		if (!rst && (ack !== 1'b0 || fault !== 1'b0)) begin
			if (expq.size() == 0) begin
				chk(65'h1, 65'h0);
			end else begin
				chk({fault, rdata}, expq.pop_front());
			end
		end
	end

	// hang guard, far above the roughly 130 cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(11));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		clr <= 1'b0;
		b = 6'($urandom);
		d = {$urandom, $urandom};
		acc(SEL_CTRL, 1'b0, 64'h0, 2'h0, OK_W);
		acc(SEL_CNT0, 1'b0, 64'h0, 2'h0, OK_W);
		acc(SEL_CTRL, 1'b1, d, 2'h0, OK_W);
		acc(SEL_CTRL, 1'b0, 64'h0, 2'h0, {33'h0, d[31:0] & CTRL_MASK});
		acc(SEL_CTRL, 1'b1, 64'h0, 2'h3, FLT);
		acc(SEL_CTRL, 1'b0, 64'h0, 2'h0, {33'h0, d[31:0] & CTRL_MASK});
		acc(2'h3, 1'b0, 64'h0, 2'h0, FLT);
		acc(SEL_CNT1, 1'b1, d, 2'h0, OK_W);
		acc(SEL_CNT1, 1'b0, 64'h0, 2'h0, {25'h0, d[39:0]});
		acc(SEL_CNT1, 1'b1, 64'h0, 2'h0, OK_W);
		acc(SEL_CTRL, 1'b1, ctl(3'h1, 1'b0, 3'h5, 1'b0), 2'h0, OK_W);
		burst(40, 2'h3);
		acc(SEL_CTRL, 1'b1, ctl(3'h2, 1'b0, 3'h4, 1'b0), 2'h0, OK_W);
		burst(10, 2'h0);
		@(posedge clk);
		plvl <= 2'h3;
		burst(20, 2'h1);
		plvl <= 2'h0;
		repeat (6) @(posedge clk);
		chk(65'(n0), 65'(p0));
		chk(65'(n1), 65'(p1));
		acc(SEL_CNT0, 1'b0, 64'h0, 2'h0, {25'h0, e0});
		acc(SEL_CNT1, 1'b0, 64'h0, 2'h0, {25'h0, e1});
		acc(SEL_CNT0, 1'b1, 64'hff_ffff_ffff, 2'h0, OK_W);
		acc(SEL_CTRL, 1'b1, ctl(3'h3, 1'b1, 3'h0, 1'b0), 2'h0, OK_W);
		@(posedge clk);
		evt <= 64'h1 << b;
		repeat (2) @(posedge clk);
		evt <= 64'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(65'(pin0), 65'h0);
		@(negedge clk);
		chk(65'(pin0), 65'h1);
		@(negedge clk);
		chk(65'(pin0), 65'h0);
		acc(SEL_CNT0, 1'b0, 64'h0, 2'h0, 65'h1);
		for (int k = 1; k < 3; k++) begin
			@(posedge clk);
			bpm <= 1'b1;
			bpx <= 2'(k);
			@(posedge clk);
			@(negedge clk);
			chk(65'({pin1, pin0}), 65'(k));
		end
		repeat (2) @(posedge clk);
		chk(65'(expq.size()), 65'h0);
		print_verdict();
	end
endmodule
